// ---- pkg/sample_ctrl_params.svh ----
// timing counts and reset values for the sampling converter control
`ifndef SAMPLE_CTRL_PARAMS_SVH
`define SAMPLE_CTRL_PARAMS_SVH
`define CLK_SYS_MHZ 250
`define CONV_TIME_PER_CH_NS 2000
`define CONV_TIME_PER_CH_CYC ((`CONV_TIME_PER_CH_NS * `CLK_SYS_MHZ) / 1000)
`define MODE_RESET 4'h0
`define MODE_PDOWN_BIT 3
`define MODE_BANK_BIT 2
`define RESULT_WIDTH 12
`define NUM_TRACKS 4
`define EXT_CLK_DIV 4
`endif

// ---- pkg/sample_ctrl_pkg.sv ----
// types for the sampling converter control
`default_nettype none
package sample_ctrl_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01,
        ST_DONE = 2'b11
    } seq_state_e;
    typedef logic [11:0] result_t;
endpackage
`default_nettype wire

// ---- logic/result_buffer.sv ----
// two-entry buffer between converter and result memory
`timescale 1ns/100ps
`default_nettype none
module result_buffer
    import sample_ctrl_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_srst,
    // fill side
    input wire logic i_valid,
    input wire result_t i_data,
    output logic o_ready,
    // drain side
    output logic o_valid,
    output result_t o_data,
    input wire logic i_ready
);
    result_t mem [2];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    logic push;
    logic pop;

    assign push = i_valid && (count != 2'd2);
    assign pop = (count != 2'd0) && i_ready;
    assign o_ready = (count != 2'd2);
    assign o_valid = (count != 2'd0);
    assign o_data = mem[rd_ptr];

    always_ff @(posedge i_clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= i_data;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'd0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule
`default_nettype wire

// ---- logic/sample_ctrl.sv ----
// control and host port of the four-track sampling converter
//
// Function
// - internal clock when clock pin tied high
// - chip select low enables read and write strobes
// - write strobe low transfers mode code
// - read strobe low drives a result
// - trigger rising edge samples, starts sequence
// - completion flag falls after last conversion
// - twelve bit result, top pin is msb
// - low data pins double as mode bits
// - decode power-down, bank, channel count
// - latch mode on write or select rise
// - reads return channels in order, wrap
// - deselected: ignore read and write strobes, release data pins
`timescale 1ns/100ps
`default_nettype none
`include "sample_ctrl_params.svh"
module sample_ctrl
    import sample_ctrl_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_srst,
    // host port strobes
    input wire logic i_chip_select_n,
    input wire logic i_write_n,
    input wire logic i_read_n,
    input wire logic i_sample_trigger_n,
    // converter clock pin, high means internal clock
    input wire logic i_clk_pin,
    // mode pins
    input wire logic i_mode_bit0,
    input wire logic i_mode_bit1,
    // shared data pins
    input wire logic [11:0] i_data,
    output logic [11:0] o_data,
    output logic [11:0] o_data_oe,
    // completion flag
    output logic o_done_n,
    // analog front end
    output logic o_hold,
    output logic o_bank_b,
    output logic o_power_down,
    output logic [1:0] o_conv_channel,
    output logic o_conv_start,
    input wire result_t i_conv_result,
    input wire logic i_conv_valid,
    output logic o_conv_ready
);
    localparam int CYC = `CONV_TIME_PER_CH_CYC;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [1:0] cs_s;
    logic [1:0] wr_s;
    logic [1:0] rd_s;
    logic [1:0] tr_s;
    logic [1:0] ck_s;
    logic [1:0] m0_s;
    logic [1:0] m1_s;
    logic [1:0] m2_s;
    logic [1:0] m3_s;
    logic cs_q;
    logic wr_q;
    logic rd_q;
    logic tr_q;
    logic ck_q;

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            cs_s <= 2'b11;
            wr_s <= 2'b11;
            rd_s <= 2'b11;
            tr_s <= 2'b11;
            ck_s <= 2'b11;
            m0_s <= 2'b00;
            m1_s <= 2'b00;
            m2_s <= 2'b00;
            m3_s <= 2'b00;
            cs_q <= 1'b1;
            wr_q <= 1'b1;
            rd_q <= 1'b1;
            tr_q <= 1'b1;
            ck_q <= 1'b1;
        end else begin
            cs_s <= {cs_s[0], i_chip_select_n};
            wr_s <= {wr_s[0], i_write_n};
            rd_s <= {rd_s[0], i_read_n};
            tr_s <= {tr_s[0], i_sample_trigger_n};
            ck_s <= {ck_s[0], i_clk_pin};
            m0_s <= {m0_s[0], i_mode_bit0};
            m1_s <= {m1_s[0], i_mode_bit1};
            m2_s <= {m2_s[0], i_data[0]};
            m3_s <= {m3_s[0], i_data[1]};
            cs_q <= cs_s[1];
            wr_q <= wr_s[1];
            rd_q <= rd_s[1];
            tr_q <= tr_s[1];
            ck_q <= ck_s[1];
        end
    end

    logic wr_act;
    logic wr_end;
    logic rd_fall;
    logic trig_rise;
    logic ext_tick;
    assign wr_act = !cs_s[1] && !wr_s[1];
    assign wr_end = !cs_q && !wr_q && !wr_act;
    assign rd_fall = !cs_s[1] && !rd_s[1] && (cs_q || rd_q);
    assign trig_rise = tr_s[1] && !tr_q;
    assign ext_tick = ck_s[1] && !ck_q;

    ////////////////////////////////////////////////////////////////////////
    // mode register
    logic [3:0] mode;
    logic [3:0] next_mode;
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            mode <= `MODE_RESET;
            next_mode <= `MODE_RESET;
        end else begin
            if (wr_act) begin
                next_mode <= {m3_s[1], m2_s[1], m1_s[1], m0_s[1]};
            end
            if (wr_end) begin
                mode <= next_mode;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clock source: steady high pin selects internal timebase
    logic [7:0] hi_cnt;
    logic int_clk;
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            hi_cnt <= 8'h00;
            int_clk <= 1'b1;
        end else begin
            if (!ck_s[1]) begin
                hi_cnt <= 8'h00;
                int_clk <= 1'b0;
            end else if (hi_cnt != 8'hff) begin
                hi_cnt <= hi_cnt + 8'h01;
            end else begin
                int_clk <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer
    seq_state_e state;
    logic [12:0] tcnt;
    logic [1:0] ch;
    logic tick;
    logic last_ch;
    assign tick = int_clk ? 1'b1 : ext_tick;
    assign last_ch = (ch == mode[1:0]);
    // a trigger only counts when it really starts a sequence
    logic seq_go;
    assign seq_go = trig_rise && !mode[`MODE_PDOWN_BIT] && (state == ST_IDLE);

    logic buf_ready;
    logic buf_valid;
    result_t buf_data;
    logic slot_free;
    assign slot_free = buf_ready;

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            state <= ST_IDLE;
            tcnt <= 13'h0000;
            ch <= 2'b00;
            o_hold <= 1'b0;
            o_conv_start <= 1'b0;
            o_done_n <= 1'b1;
        end else begin
            o_conv_start <= 1'b0;
            if (rd_fall) begin
                o_done_n <= 1'b1;
            end
            unique case (state)
                ST_IDLE: begin
                    if (trig_rise && !mode[`MODE_PDOWN_BIT]) begin
                        state <= ST_CONV;
                        o_hold <= 1'b1;
                        o_done_n <= 1'b1;
                        ch <= 2'b00;
                        tcnt <= 13'h0000;
                        o_conv_start <= 1'b1;
                    end
                end
                ST_CONV: begin
                    if (tick && tcnt < 13'(CYC - 1)) begin
                        tcnt <= tcnt + 13'h0001;
                    end else if (tcnt >= 13'(CYC - 1) && slot_free) begin
                        tcnt <= 13'h0000;
                        if (last_ch) begin
                            state <= ST_DONE;
                        end else begin
                            ch <= ch + 2'b01;
                            o_conv_start <= 1'b1;
                        end
                    end
                end
                ST_DONE: begin
                    if (!buf_valid) begin
                        o_hold <= 1'b0;
                        o_done_n <= 1'b0;
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_bank_b <= 1'b0;
            o_power_down <= 1'b0;
            o_conv_channel <= 2'b00;
            o_conv_ready <= 1'b0;
        end else begin
            o_bank_b <= mode[`MODE_BANK_BIT];
            o_power_down <= mode[`MODE_PDOWN_BIT];
            o_conv_channel <= ch;
            o_conv_ready <= buf_ready;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // result buffer and memory
    result_buffer u_buf (
        .i_clk_sys(i_clk_sys),
        .i_srst(i_srst),
        .i_valid(i_conv_valid),
        .i_data(i_conv_result),
        .o_ready(buf_ready),
        .o_valid(buf_valid),
        .o_data(buf_data),
        .i_ready(1'b1)
    );

    result_t mem [`NUM_TRACKS];
    logic [1:0] wptr;
    logic [1:0] rptr;
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            wptr <= 2'b00;
        end else if (seq_go) begin
            wptr <= 2'b00;
        end else if (buf_valid) begin
            mem[wptr] <= buf_data;
            wptr <= wptr + 2'b01;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            rptr <= 2'b00;
        end else if (seq_go) begin
            rptr <= 2'b00;
        end else if (rd_fall) begin
            rptr <= rptr + 2'b01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // data pin drive
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_data <= 12'h000;
            o_data_oe <= 12'h000;
        end else if (!cs_s[1] && !rd_s[1]) begin
            if (rd_fall) begin
                o_data <= mem[rptr];
            end
            o_data_oe <= 12'hfff;
        end else begin
            o_data_oe <= 12'h000;
        end
    end
endmodule
`default_nettype wire

// ---- testbench/sample_ctrl_sva.sv ----
// port assertions for the converter control
`timescale 1ns/100ps
`default_nettype none
module sample_ctrl_sva (
    input wire logic i_clk_sys, i_srst, i_chip_select_n, i_write_n,
    input wire logic i_read_n, i_sample_trigger_n,
    input wire logic [11:0] i_data, o_data_oe,
    input wire logic o_done_n, o_hold, o_power_down, o_conv_start
);
    logic [11:0] hold_cnt;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);
    // cycles spent holding, for the sequence time bound
    always_ff @(posedge i_clk_sys) begin
        if (i_srst || !o_hold) hold_cnt <= 12'h000;
        else hold_cnt <= hold_cnt + 12'h001;
    end
    chk_deselect_float: assert property (
        i_chip_select_n [*6] |-> o_data_oe == 12'h000) else $error("oe");
    chk_oe_whole_word: assert property (
        o_data_oe == 12'h000 || o_data_oe == 12'hfff) else $error("oew");
    chk_oe_read_cause: assert property (
        $rose(o_data_oe[0])
        |-> !$past(i_chip_select_n, 2) && !$past(i_read_n, 2))
        else $error("oer");
    chk_start_in_hold: assert property (
        o_conv_start |-> o_hold) else $error("start");
    chk_trigger_holds: assert property (
        $rose(i_sample_trigger_n) && !o_hold && !o_power_down
        |-> ##[1:5] o_hold) else $error("trig");
    chk_done_after_hold: assert property (
        $fell(o_done_n) |-> !o_hold) else $error("done");
    chk_hold_bound: assert property (
        hold_cnt < 12'h7f0) else $error("long");
    chk_done_clear: assert property (
        !o_done_n && $fell(i_read_n) && !i_chip_select_n
        |-> ##[1:6] o_done_n) else $error("clr");
    chk_pdown_refuse: assert property (
        o_power_down && $past(o_power_down, 4) |-> !$rose(o_hold))
        else $error("pd");
    chk_mode_latch: assert property (
        $rose(i_write_n) && !i_chip_select_n
        |-> ##6 o_power_down == $past(i_data[1], 6)) else $error("mode");
    cover property ($fell(o_done_n));
    cover property ($rose(o_data_oe[0]));
    cover property (o_power_down && $rose(i_sample_trigger_n));
endmodule
bind sample_ctrl sample_ctrl_sva u_sample_ctrl_sva (
    .i_clk_sys(i_clk_sys),
    .i_srst(i_srst),
    .i_chip_select_n(i_chip_select_n),
    .i_write_n(i_write_n),
    .i_read_n(i_read_n),
    .i_sample_trigger_n(i_sample_trigger_n),
    .i_data(i_data),
    .o_data_oe(o_data_oe),
    .o_done_n(o_done_n),
    .o_hold(o_hold),
    .o_power_down(o_power_down),
    .o_conv_start(o_conv_start)
);
`default_nettype wire

// ---- testbench/conv_model.sv ----
// behavioural front end answering each channel start
`timescale 1ns/100ps
`default_nettype none
module conv_model
    import sample_ctrl_pkg::*;
#(
    parameter int DELAY = 12
) (
    input wire logic i_clk_sys, i_srst, i_start, i_bank_b, i_ready,
    input wire logic [1:0] i_channel,
    output result_t o_result,
    output logic o_valid
);
    int cnt;
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            cnt <= 0;
            o_valid <= 1'b0;
            o_result <= 12'h000;
        end else if (i_start) begin
            cnt <= DELAY;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
            o_result <= ~o_result;
        end else if (cnt == 1) begin
            cnt <= 0;
            o_valid <= 1'b1;
            o_result <= {i_bank_b, 1'b1, i_channel, 8'h5a};
        end else if (o_valid && i_ready) begin
            o_valid <= 1'b0;
            o_result <= ~o_result;
        end
    end
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// self-checking bench for the converter control
`timescale 1ns/100ps
`default_nettype none
`include "sample_ctrl_params.svh"
module tb_top
    import sample_ctrl_pkg::*;
;
    localparam int CH = `CONV_TIME_PER_CH_CYC;
    typedef struct {logic [3:0] mode; logic bank; int n;} row_s;
    row_s rows [8];
    logic clk = 0, srst = 1, cs_n = 1, wr_n = 1, rd_n = 1, tr_n = 1;
    logic mb0 = 0, mb1 = 0, valid, ready, start, bank, pd, hold, done_n;
    logic [11:0] host = 12'h5a5, pins, dout, oe;
    logic [1:0] chan;
    logic clk_pin = 1, ext_on = 0;
    result_t res;
    int err_count = 0, total_checks = 0, c;
    assign pins = (oe & dout) | (~oe & host);
    sample_ctrl u_sample_ctrl (.i_clk_sys(clk), .i_srst(srst),
        .i_chip_select_n(cs_n), .i_write_n(wr_n), .i_read_n(rd_n),
        .i_sample_trigger_n(tr_n), .i_clk_pin(clk_pin), .i_mode_bit0(mb0),
        .i_mode_bit1(mb1), .i_data(pins), .o_data(dout), .o_data_oe(oe),
        .o_done_n(done_n), .o_hold(hold), .o_bank_b(bank),
        .o_power_down(pd), .o_conv_channel(chan), .o_conv_start(start),
        .i_conv_result(res), .i_conv_valid(valid), .o_conv_ready(ready));
    conv_model u_conv_model (.i_clk_sys(clk), .i_srst(srst),
        .i_start(start), .i_bank_b(bank), .i_ready(ready),
        .i_channel(chan), .o_result(res), .o_valid(valid));
    initial forever #2 clk = ~clk;
    // converter clock pin: half duty while running, tied high otherwise
    initial forever begin
        @(posedge clk);
        #1;
        clk_pin = ext_on ? ~clk_pin : 1'b1;
    end
    task automatic step(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic cmp(string s, logic [11:0] e, logic [11:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic cmp_cyc(int lo, int hi);
        total_checks++;
        if (c < lo || c > hi) begin
            err_count++;
            $display("MISMATCH cycles exp %0d..%0d got %0d", lo, hi, c);
        end
    endtask
    function automatic logic [11:0] f(logic b, int k);
        return {b, 1'b1, k[1:0], 8'h5a};
    endfunction
    task automatic wr(logic [3:0] m, logic cs_end = 1'b0);
        cs_n = 0;
        host[1:0] = m[3:2];
        {mb1, mb0} = m[1:0];
        step(1);
        wr_n = 0;
        step(4);
        if (cs_end) begin
            cs_n = 1;
        end else begin
            wr_n = 1;
        end
        step(6);
        cs_n = 1;
        wr_n = 1;
        host = ~host;
        step(2);
    endtask
    task automatic conv();
        tr_n = 0;
        step(4);
        tr_n = 1;
        c = 0;
    endtask
    task automatic wait_done();
        while (done_n !== 1'b0 && c < 3000) begin
            step(1);
            c++;
        end
    endtask
    task automatic rd(logic [11:0] e);
        cs_n = 0;
        rd_n = 0;
        step(6);
        cmp("oe", 12'hfff, oe);
        cmp("data", e, dout);
        rd_n = 1;
        step(4);
        cmp("done_n", 1, done_n);
        cs_n = 1;
        step(8);
        cmp("oe_off", 0, oe);
    endtask
    task automatic test_done();
        if (err_count == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        rows = '{'{4'h0, 1'b0, 1}, '{4'h1, 1'b0, 2}, '{4'h2, 1'b0, 3},
            '{4'h3, 1'b0, 4}, '{4'h4, 1'b1, 1}, '{4'h5, 1'b1, 2},
            '{4'h6, 1'b1, 3}, '{4'h7, 1'b1, 4}};
        step(8);
        srst = 0;
        step(300);
        foreach (rows[i]) begin
            wr(rows[i].mode);
            conv();
            wait_done();
            cmp_cyc(CH * rows[i].n, CH * rows[i].n + 40);
            cmp("done", 0, done_n);
            cmp("bank", rows[i].bank, bank);
            for (int k = 0; k < rows[i].n; k++) begin
                rd(f(rows[i].bank, k));
            end
        end
        rd(f(1'b1, 0));
        conv();
        step(600);
        conv();
        c = 604;
        wait_done();
        cmp_cyc(4 * CH, 4 * CH + 40);
        rd_n = 0;
        step(6);
        cmp("oe_desel", 0, oe);
        cmp("done_desel", 0, done_n);
        rd_n = 1;
        srst = 1;
        step(2);
        srst = 0;
        cmp("rst_done", 1, done_n);
        cmp("rst_mode", 0, {pd, bank});
        step(300);
        conv();
        wait_done();
        cmp_cyc(CH, CH + 40);
        rd(f(1'b0, 0));
        ext_on = 1;
        wr(4'h4, 1'b1);
        cmp("bank_cs", 1, bank);
        conv();
        wait_done();
        cmp_cyc(2 * CH, 2 * CH + 40);
        rd(f(1'b1, 0));
        ext_on = 0;
        step(300);
        wr(4'h8);
        cmp("pdown", 1, pd);
        conv();
        step(CH + 100);
        cmp("pd_hold", 0, hold);
        cmp("pd_done", 1, done_n);
        test_done();
    end
    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        test_done();
    end
endmodule
`default_nettype wire
